// [inc/mddr_pkg.sv]
// shared constants and types of the low-power ddr command/address core
package mddr_pkg;
  localparam int CA_W = 10;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam int ROW_W = 14;
  localparam int COL_W = 10;
  localparam int BURST_BEATS = 4;
  localparam int BEAT_W = 2;
  localparam int AB_POS = 4;
  localparam int AUTO_CLOSE_POS = 0;
  localparam int LANE_W = 8;
  localparam logic [1:0] OP_ACT = 2'h2;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h5;
  localparam logic [2:0] OP_SELF = 3'h4;
  localparam logic [2:0] OP_DEEP = 3'h3;
  localparam logic [3:0] OP_PRE = 4'hB;
  localparam logic [BEAT_W-1:0] LAST_BEAT = 2'h3;
  localparam logic [NUM_BANKS-1:0] BANKS_RST = 8'h00;
  localparam logic [ROW_W-1:0] ROW_RST = 14'h0000;
  localparam logic [COL_W-1:0] COL_RST = 10'h000;
  localparam logic [COL_W-1:0] COL_STEP = 10'h001;
  typedef enum logic [1:0] {B_IDLE, B_WRITE, B_READ} burst_t;
  typedef enum logic [1:0] {P_AWAKE, P_POWER_DOWN, P_SELF_REFRESH, P_DEEP_SLEEP} power_t;
endpackage

// [inc/store_if.sv]
// port between the command core and its byte-lane storage array
`timescale 1ns/1ps
interface store_if #(parameter int DATA_W = 32, parameter int ADDR_W = 8);
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W/8-1:0] lane_we;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport ctrl(output wr_en, output wr_addr, output rd_addr, output lane_we, output wdata,
               input rdata);
  modport mem(input wr_en, input wr_addr, input rd_addr, input lane_we, input wdata,
              output rdata);
endinterface

// [src/lane_store.sv]
// storage array written a whole word at a time, each byte lane under its own enable
`timescale 1ns/1ps
module lane_store import mddr_pkg::*; #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  store_if.mem port
);
  localparam int LANES = DATA_W / LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  logic [DATA_W-1:0] mem [DEPTH];
  wire [DATA_W-1:0] merged;

  always_ff @(posedge ref_clk) begin
    port.rdata <= mem[port.rd_addr];
  end

  // one writer for the whole word keeps the array single-driven; masked lanes write back old bytes
  always_ff @(posedge ref_clk) begin
    if (port.wr_en) begin
      mem[port.wr_addr] <= merged;
    end
  end

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    // lane g owns data bits 8g..8g+7; a cleared enable leaves the byte untouched
    assign merged[g*LANE_W +: LANE_W] = port.lane_we[g] ? port.wdata[g*LANE_W +: LANE_W]
                                                        : mem[port.wr_addr][g*LANE_W +: LANE_W];
    lane_map_a: assert property (@(posedge ref_clk) disable iff (rst)
      port.lane_we[g] |=> mem[$past(port.wr_addr)][g*LANE_W +: LANE_W]
        == $past(port.wdata[g*LANE_W +: LANE_W]))
      else $error("byte lane did not store its own eight data bits");
  end
endmodule

// [src/mddr_core.sv]
// command/address decode, bank state, bursts and sleep states of the memory device
`timescale 1ns/1ps
// What this block does
// - chip select high: command, address and data inputs ignored, bursts continue
// - activate: row and bank bits taken from rising and falling halves
// - read/write: column 1..9 and bank placement, column bit zero forced low
// - auto-close flag on read/write closes the bank after the burst
// - three bank bits form binary bank number 0..7
// - masked write byte not stored, burst column still advances
// - strobes driven by device on reads, by controller on writes
// - lane n carries data bits 8n..8n+7 with its own strobe and mask
// - chip select and clock enable sampled only at rising edge
// - clock enable falling with self-refresh code enters self-refresh
module mddr_core import mddr_pkg::*; #(
  parameter int DATA_W = 32,
  parameter int MEM_COL_W = 5
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic cke,
  input wire logic [CA_W-1:0] cmd_addr_rise,
  input wire logic [CA_W-1:0] cmd_addr_fall,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [DATA_W/LANE_W-1:0] write_byte_mask,
  output logic [DATA_W-1:0] rd_data_q,
  output logic rd_valid_q,
  output logic [DATA_W/LANE_W-1:0] strobe_out_q,
  output logic [DATA_W/LANE_W-1:0] strobe_oe_q,
  output logic [NUM_BANKS-1:0] bank_open_q,
  output power_t power_q
);
  localparam int LANES = DATA_W / LANE_W;
  localparam int ADDR_W = BANK_W + MEM_COL_W;

  function automatic logic [BANK_W-1:0] cmd_bank(input logic [CA_W-1:0] rise);
    cmd_bank = rise[9:7];
  endfunction

  function automatic logic [ROW_W-1:0] cmd_row(input logic [CA_W-1:0] rise,
                                               input logic [CA_W-1:0] fall);
    cmd_row = {fall[8], rise[6:2], fall[7:0]};
  endfunction

  function automatic logic [COL_W-1:0] cmd_col(input logic [CA_W-1:0] rise,
                                               input logic [CA_W-1:0] fall);
    cmd_col = {fall[7:1], rise[6:5], 1'b0};
  endfunction

  logic cke_prev_q;
  power_t power_d;
  burst_t burst_st_q;
  logic [BEAT_W-1:0] beat_q;
  logic [COL_W-1:0] col_q;
  logic [BANK_W-1:0] bank_q;
  logic ap_q;
  logic rd_pending_q;
  logic [NUM_BANKS-1:0] bank_open_d;
  logic [ROW_W-1:0] row_q [NUM_BANKS];

  store_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) store ();

  lane_store #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_store (
    .ref_clk(ref_clk),
    .rst(rst),
    .port(store.mem)
  );

  // activate, read, write and precharge only count while both samples of clock enable are high and chip select is low
  wire awake_cmd = (power_q == P_AWAKE) && cke_prev_q && cke && !cs_n;
  wire act_cmd = awake_cmd && (cmd_addr_rise[1:0] == OP_ACT);
  wire wr_cmd = awake_cmd && (cmd_addr_rise[2:0] == OP_WRITE);
  wire rd_cmd = awake_cmd && (cmd_addr_rise[2:0] == OP_READ);
  wire pre_cmd = awake_cmd && (cmd_addr_rise[3:0] == OP_PRE);
  wire col_cmd = wr_cmd || rd_cmd;
  wire cke_fall = (power_q == P_AWAKE) && cke_prev_q && !cke;
  wire sr_entry = cke_fall && !cs_n && (cmd_addr_rise[2:0] == OP_SELF);
  wire dpd_entry = cke_fall && !cs_n && (cmd_addr_rise[2:0] == OP_DEEP);
  wire [BANK_W-1:0] cmd_bank_w = cmd_bank(cmd_addr_rise);
  wire [ROW_W-1:0] cmd_row_w = cmd_row(cmd_addr_rise, cmd_addr_fall);
  wire [COL_W-1:0] cmd_col_w = cmd_col(cmd_addr_rise, cmd_addr_fall);
  wire burst_last = (burst_st_q != B_IDLE) && (beat_q == LAST_BEAT);
  // write beats seen with chip select high are dropped, the burst still moves on
  wire beat_take = (burst_st_q == B_WRITE) && !cs_n;

  assign store.wr_en = beat_take;
  assign store.lane_we = ~write_byte_mask & {LANES{beat_take}};
  assign store.wr_addr = {bank_q, col_q[MEM_COL_W-1:0]};
  assign store.rd_addr = {bank_q, col_q[MEM_COL_W-1:0]};
  assign store.wdata = wr_data;

  always_comb begin
    bank_open_d = bank_open_q;
    if (burst_last && ap_q) begin
      bank_open_d[bank_q] = 1'b0;
    end
    if (act_cmd) begin
      bank_open_d[cmd_bank_w] = 1'b1;
    end
    if (pre_cmd) begin
      if (cmd_addr_rise[AB_POS]) begin
        bank_open_d = BANKS_RST;
      end else begin
        bank_open_d[cmd_bank_w] = 1'b0;
      end
    end
  end

  always_comb begin
    power_d = power_q;
    case (power_q)
      P_AWAKE: begin
        if (sr_entry) begin
          power_d = P_SELF_REFRESH;
        end else if (dpd_entry) begin
          power_d = P_DEEP_SLEEP;
        end else if (cke_fall) begin
          power_d = P_POWER_DOWN;
        end
      end
      P_POWER_DOWN, P_SELF_REFRESH, P_DEEP_SLEEP: begin
        if (cke) begin
          power_d = P_AWAKE;
        end
      end
      default: power_d = P_AWAKE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cke_prev_q <= 1'b0;
      power_q <= P_AWAKE;
      bank_open_q <= BANKS_RST;
    end else begin
      cke_prev_q <= cke;
      power_q <= power_d;
      bank_open_q <= bank_open_d;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        row_q[b] <= ROW_RST;
      end
    end else if (act_cmd) begin
      row_q[cmd_bank_w] <= cmd_row_w;
    end
  end

  // a new column command restarts the burst; spacing keeps this from cutting one short
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      burst_st_q <= B_IDLE;
      beat_q <= '0;
      col_q <= COL_RST;
      bank_q <= '0;
      ap_q <= 1'b0;
    end else if (col_cmd) begin
      burst_st_q <= wr_cmd ? B_WRITE : B_READ;
      beat_q <= '0;
      col_q <= cmd_col_w;
      bank_q <= cmd_bank_w;
      ap_q <= cmd_addr_fall[AUTO_CLOSE_POS];
    end else if (burst_last) begin
      burst_st_q <= B_IDLE;
      ap_q <= 1'b0;
    end else if (burst_st_q != B_IDLE) begin
      beat_q <= beat_q + 2'h1;
      col_q <= col_q + COL_STEP;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_pending_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
      strobe_oe_q <= '0;
      strobe_out_q <= '0;
    end else begin
      rd_pending_q <= (burst_st_q == B_READ);
      rd_valid_q <= rd_pending_q;
      rd_data_q <= rd_pending_q ? store.rdata : '0;
      strobe_oe_q <= {LANES{rd_pending_q}};
      strobe_out_q <= rd_pending_q ? ~strobe_out_q : '0;
    end
  end

  cs_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cs_n && !burst_last) |=> $stable(bank_open_q))
    else $error("bank state changed while chip select was high");

  act_row_a: assert property (@(posedge ref_clk) disable iff (rst)
    act_cmd |=> bank_open_q[$past(cmd_bank_w)] && row_q[$past(cmd_bank_w)] == $past(cmd_row_w))
    else $error("activate did not open the addressed row");

  col_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
    col_cmd |=> (col_q == $past(cmd_col_w)) && !col_q[0])
    else $error("column address misplaced or bit zero set");

  auto_close_a: assert property (@(posedge ref_clk) disable iff (rst)
    (burst_last && ap_q && !act_cmd) |=> !bank_open_q[$past(bank_q)])
    else $error("auto-close burst left its bank open");

  bank_seven_a: assert property (@(posedge ref_clk) disable iff (rst)
    (act_cmd && cmd_addr_rise[9:7] == 3'h7) |=> bank_open_q[7])
    else $error("all-high bank bits did not select bank 7");

  mask_advance_a: assert property (@(posedge ref_clk) disable iff (rst)
    (burst_st_q == B_WRITE && !burst_last && !col_cmd) |=> col_q == $past(col_q) + COL_STEP)
    else $error("write burst column did not advance");

  read_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_cmd && !cs_n) |-> ##3 (strobe_oe_q == {LANES{1'b1}}))
    else $error("device did not drive strobes for read data");

  write_release_a: assert property (@(posedge ref_clk) disable iff (rst)
    (burst_st_q == B_WRITE && !rd_pending_q) |=> strobe_oe_q == '0)
    else $error("device drove strobes during a write burst");

  cke_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!cke_prev_q && !burst_last) |=> $stable(bank_open_q))
    else $error("command accepted without two high clock-enable samples");

  self_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
    sr_entry |=> power_q == P_SELF_REFRESH)
    else $error("self-refresh entry not taken");

  masked_write_c: cover property (@(posedge ref_clk) disable iff (rst)
    beat_take && write_byte_mask != '0);
  auto_read_c: cover property (@(posedge ref_clk) disable iff (rst)
    burst_last && ap_q && burst_st_q == B_READ);
  self_refresh_c: cover property (@(posedge ref_clk) disable iff (rst) sr_entry);
  deep_sleep_c: cover property (@(posedge ref_clk) disable iff (rst) dpd_entry);
endmodule

// [sim/mem_ctrl_model.sv]
// memory controller model: commands, clock enable and write beats
`timescale 1ns/1ps
module mem_ctrl_model import mddr_pkg::*; (
  input wire logic ref_clk,
  output logic cs_n,
  output logic cke,
  output logic [CA_W-1:0] ca_rise,
  output logic [CA_W-1:0] ca_fall,
  output logic [31:0] wr_data,
  output logic [3:0] mask
);
  initial begin
    cs_n = 1'h1;
    cke = 1'h0;
    ca_rise = 10'h000;
    ca_fall = 10'h000;
  end
  // write data and mask stay unknown until the first beat; no burst runs to take them
  // released lines flip so a stale value never passes for a fresh one
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      cs_n = 1'h1;
      ca_rise = ~ca_rise;
      ca_fall = ~ca_fall;
      wr_data = ~wr_data;
      mask = ~mask;
    end
  endtask
  // the caller's gap keeps all command spacing minimums
  task automatic cmd(input logic cs, input logic k, input logic [CA_W-1:0] r,
                     input logic [CA_W-1:0] f, input int gap);
    @(negedge ref_clk);
    cs_n = cs;
    cke = k;
    ca_rise = r;
    ca_fall = f;
    idle(gap);
  endtask
  // write beat under a nop so the burst is not restarted
  task automatic beat(input logic [31:0] d, input logic [3:0] m);
    @(negedge ref_clk);
    cs_n = 1'h0;
    ca_rise = 10'h007;
    ca_fall = ~ca_fall;
    wr_data = d;
    mask = m;
  endtask
endmodule

// [sim/mddr_core_tb.sv]
// self-checking bench of the command/address core
`timescale 1ns/1ps
module mddr_core_tb import mddr_pkg::*;;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic cs_n, cke;
  logic [CA_W-1:0] ca_rise, ca_fall;
  logic [31:0] wr_data, rd_data_q;
  logic [3:0] mask, strobe_out_q, strobe_oe_q;
  logic rd_valid_q;
  logic [NUM_BANKS-1:0] bank_open_q;
  power_t power_q;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  always #10 ref_clk = ~ref_clk;
  mem_ctrl_model i_mem_ctrl_model (.ref_clk(ref_clk), .cs_n(cs_n), .cke(cke), .ca_rise(ca_rise),
    .ca_fall(ca_fall), .wr_data(wr_data), .mask(mask));
  mddr_core i_mddr_core (.ref_clk(ref_clk), .rst(rst),
    .cs_n(cs_n), .cke(cke), .cmd_addr_rise(ca_rise), .cmd_addr_fall(ca_fall),
    .wr_data(wr_data), .write_byte_mask(mask), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .strobe_out_q(strobe_out_q), .strobe_oe_q(strobe_oe_q), .bank_open_q(bank_open_q),
    .power_q(power_q));
  task automatic conclude();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // covers the whole run including the long deep sleep stay
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic act(input logic cs, input logic [2:0] b);
    i_mem_ctrl_model.cmd(cs, 1'h1, {b, 5'h15, OP_ACT}, {1'h0, 1'h1, 8'h5C}, 4);
  endtask
  task automatic wr(input logic [7:0] base, input logic use_mask);
    i_mem_ctrl_model.cmd(1'h0, 1'h1, {3'h2, 4'h0, OP_WRITE}, {2'h0, 7'h01, 1'h0}, 0);
    for (int i = 0; i < 4; i++)
      i_mem_ctrl_model.beat({4{base + 8'(i)}}, use_mask ? 4'h1 << i : 4'h0);
    i_mem_ctrl_model.idle(2);
  endtask
  task automatic t_reset();
    chk(bank_open_q, 32'h0, "bank reset");
    chk(power_q, P_AWAKE, "power reset");
    chk({rd_valid_q, strobe_oe_q}, 32'h0, "read reset");
  endtask
  task automatic t_banks();
    for (int b = 0; b < NUM_BANKS; b++) begin
      act(1'h0, 3'(b));
      chk(bank_open_q, (2 << b) - 1, "bank open");
    end
    i_mem_ctrl_model.cmd(1'h0, 1'h1, 10'h000, 10'h000, 5);
    i_mem_ctrl_model.cmd(1'h0, 1'h1, 10'h008, 10'h000, 2);
    chk(bank_open_q, 32'hFF, "config commands left banks alone");
    i_mem_ctrl_model.cmd(1'h0, 1'h1, {3'h5, 2'h0, 1'h0, OP_PRE}, 10'h000, 4);
    chk(bank_open_q, 32'hDF, "single close");
    i_mem_ctrl_model.cmd(1'h0, 1'h1, {3'h1, 2'h0, 1'h1, OP_PRE}, 10'h000, 4);
    chk(bank_open_q, 32'h0, "all close");
    act(1'h1, 3'h3);
    chk(bank_open_q, 32'h0, "deselected act");
  endtask
  task automatic t_mask();
    logic [31:0] e;
    act(1'h0, 3'h2);
    wr(8'hA0, 1'h0);
    wr(8'hB0, 1'h1);
    // first read beat stands from the second edge after the command edge
    i_mem_ctrl_model.cmd(1'h0, 1'h1, {3'h2, 4'h0, OP_READ}, {2'h0, 7'h01, 1'h1}, 2);
    for (int i = 0; i < 4; i++) begin
      i_mem_ctrl_model.idle(1);
      e = {4{8'hB0 + 8'(i)}};
      e[8*i +: 8] = 8'hA0 + 8'(i);
      chk(rd_valid_q, 32'h1, "read beat");
      chk(rd_data_q, e, "read data");
      chk(strobe_oe_q, 32'hF, "strobe drive");
      chk(strobe_out_q, i[0] ? 32'h0 : 32'hF, "strobe level");
    end
    i_mem_ctrl_model.idle(1);
    chk(bank_open_q, 32'h0, "auto close");
    chk({rd_valid_q, strobe_oe_q}, 32'h0, "strobe release");
  endtask
  task automatic t_power();
    logic [2:0] codes [3] = '{OP_SELF, 3'h7, OP_DEEP};
    power_t st [3] = '{P_SELF_REFRESH, P_POWER_DOWN, P_DEEP_SLEEP};
    for (int i = 0; i < 3; i++) begin
      i_mem_ctrl_model.cmd(1'h0, 1'h0, {7'h00, codes[i]}, 10'h000, 2);
      chk(power_q, st[i], "sleep entry");
      i_mem_ctrl_model.idle(i == 2 ? 25000 : 3);
      i_mem_ctrl_model.cmd(1'h1, 1'h1, 10'h000, 10'h000, 2);
      chk(power_q, P_AWAKE, "sleep exit");
      i_mem_ctrl_model.idle(8);
    end
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 1'h0;
    t_reset();
    i_mem_ctrl_model.cmd(1'h1, 1'h1, 10'h000, 10'h000, 2);
    t_banks();
    t_mask();
    t_power();
    conclude();
  end
endmodule
